// *** design/gam_pkg.sv ***
// Package for the general purpose pin multiplexer.
// Assumes a 32-bit AXI4-Lite register bus and one 40 MHz core clock.
package gam_pkg;
  localparam int PIN_COUNT = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_OUT_DATA = 8'h08;
  localparam logic [7:0] OFF_PIN_IN = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_ALT_CTRL = 8'h1C;
  localparam logic [7:0] OFF_EXP_STAT = 8'h20;
  // Pins that own an alternate function at all
  localparam logic [15:0] ALT_CAPABLE = 16'h1FFF;
  // Alternate-output pins: 0,1,7,8..12; input alternates: 2..6
  localparam logic [15:0] ALT_OUT_PINS = 16'h1F83;
  localparam logic [15:0] ALT_IN_PINS = 16'h007C;
  // Alternate control field positions (active high internally)
  localparam int ALT_PORT1 = 0;
  localparam int ALT_PORT2 = 1;
  localparam int ALT_PORT3 = 2;
  localparam int ALT_PORT4 = 3;
  localparam int ALT_PORT5 = 4;
  localparam int ALT_PORT6 = 5;
  localparam int ALT_PORT7 = 6;
  localparam int ALT_EVENT = 7;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [7:0] RST_ALT_CTRL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** design/gam_sync.sv ***
// Two flip-flop synchroniser bank for the pad inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module gam_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** design/gam_pin_mux.sv ***
// Sixteen pin general purpose I/O block with alternate function mux.
// Assumes AXI4-Lite master on clk; pad wire resolved outside from pinOe.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module gam_pin_mux
  import gam_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  // Interrupt
  output logic irqOut
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration and status
  logic [PINS-1:0] funcSel_q, dir_q, outData_q, irqEn_q;
  logic [PINS-1:0] irqStat_q, irqMask_q, pinPrev_q;
  logic [7:0] altCtrl_q;
  logic [PINS-1:0] pinSync;
  logic [3:0] expIrq_n;
  logic [PINS-1:0] effAlt, altVal, irqEvent;
  // Bus holding registers
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic respHold;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pad inputs pass two flops before any logic
  gam_sync #(.WIDTH(PINS)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Alternate only where the pin has one; 13..15 never do
  assign effAlt = funcSel_q & ALT_CAPABLE[PINS-1:0];

  // Alternate output levels; control bits are active high, pins low
  // Released resets idle high so downstream parts leave reset
  always_comb begin
    altVal = '1;
    altVal[0] = ~altCtrl_q[ALT_PORT2];
    altVal[1] = ~altCtrl_q[ALT_PORT4];
    altVal[7] = ~altCtrl_q[ALT_EVENT];
    altVal[8] = ~altCtrl_q[ALT_PORT1];
    altVal[9] = ~altCtrl_q[ALT_PORT3];
    altVal[10] = ~altCtrl_q[ALT_PORT5];
    altVal[11] = ~altCtrl_q[ALT_PORT6];
    altVal[12] = ~altCtrl_q[ALT_PORT7];
  end

  // Expander interrupts only count when their alternate is chosen
  // Unselected lines read as idle, so stray pad levels never count
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      expIrq_n[i] = effAlt[2 + i] ? pinSync[2 + i] : 1'b1;
    end
  end

  // Pad drivers registered so outputs come straight from flops
  // A select change moves enable and level on the same edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut <= '0;
      pinOe <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (effAlt[i]) begin
          // Input alternates (2..6, pin 6 reserved) never drive
          pinOe[i] <= ALT_OUT_PINS[i];
          pinOut[i] <= ALT_OUT_PINS[i] ? altVal[i] : 1'b0;
        end else begin
          pinOe[i] <= dir_q[i];
          pinOut[i] <= outData_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: GPIO pins on any edge, expander lines on falling
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinPrev_q <= '1;
    end else begin
      pinPrev_q <= pinSync;
    end
  end

  // Edges come from the synchronised copy only, never the raw pad
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (effAlt[i] && ALT_IN_PINS[i]) begin
        // Active-low expander request, pin 6 reserved gives none
        irqEvent[i] = (i >= 2 && i <= 5) && pinPrev_q[i] && !pinSync[i];
      end else if (effAlt[i]) begin
        irqEvent[i] = 1'b0;
      end else begin
        irqEvent[i] = irqEn_q[i] && !dir_q[i]
          && (pinPrev_q[i] != pinSync[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  // One write in flight; its response must be taken before the next
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_q)
          OFF_FUNC_SEL, OFF_DIR, OFF_OUT_DATA, OFF_IRQ_EN, OFF_IRQ_STAT,
          OFF_IRQ_MASK, OFF_ALT_CTRL: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A response the master has not yet taken keeps both slots closed
  assign respHold = s_axi_bvalid && !s_axi_bready;

  // Ready only while the holding slot is empty and no answer waits
  // Registered readies cost a cycle per handshake but stay glitch free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !(awHeld_q || (s_axi_awvalid && s_axi_awready))
        && !doWrite && !respHold;
      s_axi_wready <= !(wHeld_q || (s_axi_wvalid && s_axi_wready))
        && !doWrite && !respHold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // Partial strobes update only the byte lanes they name
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      funcSel_q <= RST_ZERO;
      dir_q <= RST_ZERO;
      outData_q <= RST_ZERO;
      irqEn_q <= RST_ZERO;
      irqMask_q <= RST_ZERO;
      altCtrl_q <= RST_ALT_CTRL;
    end else if (doWrite) begin
      unique case (awAddr_q)
        OFF_FUNC_SEL: funcSel_q <= mergeLanes(funcSel_q, wData_q, wStrb_q);
        OFF_DIR: dir_q <= mergeLanes(dir_q, wData_q, wStrb_q);
        OFF_OUT_DATA: outData_q <= mergeLanes(outData_q, wData_q, wStrb_q);
        OFF_IRQ_EN: irqEn_q <= mergeLanes(irqEn_q, wData_q, wStrb_q);
        OFF_IRQ_MASK: irqMask_q <= mergeLanes(irqMask_q, wData_q, wStrb_q);
        OFF_ALT_CTRL: begin
          if (wStrb_q[0]) begin
            altCtrl_q <= wData_q[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky status: a new event wins over a write-one clear
  // A clear never hides an event that lands in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_q <= RST_ZERO;
    end else begin
      if (doWrite && awAddr_q == OFF_IRQ_STAT) begin
        irqStat_q <= (irqStat_q & ~mergeLanes(RST_ZERO, wData_q, wStrb_q))
          | irqEvent;
      end else begin
        irqStat_q <= irqStat_q | irqEvent;
      end
    end
  end

  // Level interrupt from any unmasked status bit
  // One cycle behind the status so the output comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(irqStat_q & irqMask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data
  // The address is decoded straight off the bus at the accepting edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          OFF_FUNC_SEL: s_axi_rdata[15:0] <= funcSel_q;
          OFF_DIR: s_axi_rdata[15:0] <= dir_q;
          OFF_OUT_DATA: s_axi_rdata[15:0] <= outData_q;
          OFF_PIN_IN: s_axi_rdata[15:0] <= pinSync;
          OFF_IRQ_EN: s_axi_rdata[15:0] <= irqEn_q;
          OFF_IRQ_STAT: s_axi_rdata[15:0] <= irqStat_q;
          OFF_IRQ_MASK: s_axi_rdata[15:0] <= irqMask_q;
          OFF_ALT_CTRL: s_axi_rdata[7:0] <= altCtrl_q;
          OFF_EXP_STAT: s_axi_rdata[3:0] <= ~expIrq_n;
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/gam_pin_mux_monitor.sv ***
// Checker for the pin mux: bus answers and pad enables.
// Assumes binding into gam_pin_mux and writes with every strobe set.
`timescale 1ns/100ps
`default_nettype none
module gam_pin_mux_monitor
  import gam_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pads and interrupt
  input wire logic [PINS-1:0] pinOe,
  input wire logic irqOut
);
  logic [7:0] awAddr_q;
  logic [PINS-1:0] wData_q, dir_q, fsel_q;
  ////////////////////////////////////////////////////////////////////////////
  // Capture each write as its channels are taken
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) awAddr_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wData_q <= s_axi_wdata[PINS-1:0];
  end
  // Commit at the response, when the pads have surely settled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_q <= 16'h0000;
      fsel_q <= 16'h0000;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (awAddr_q == OFF_DIR) dir_q <= wData_q;
      if (awAddr_q == OFF_FUNC_SEL) fsel_q <= wData_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  gpio_dir_a: assert property (
    !s_axi_bvalid |-> ((pinOe ^ dir_q) & ~(fsel_q & ALT_CAPABLE)) == 16'h0000)
    else $error("gpio pad enable differs from direction");
  alt_in_a: assert property (
    !s_axi_bvalid |-> (pinOe & fsel_q & ALT_IN_PINS) == 16'h0000)
    else $error("input alternate pad is driven");
  alt_out_a: assert property (
    !s_axi_bvalid |-> (~pinOe & fsel_q & ALT_OUT_PINS) == 16'h0000)
    else $error("output alternate pad not driven");
  rst_quiet_a: assert property (
    $fell(sys_rst) |-> pinOe == 16'h0000 && !irqOut)
    else $error("outputs active right after reset");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_ans_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted with data pending");
endmodule
bind gam_pin_mux gam_pin_mux_monitor #(.PINS(PINS)) mon (
  .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pinOe, .irqOut);
`default_nettype wire

// *** verification/gam_board.sv ***
// Board side of the pads: pull-ups and open-drain expander lines.
// Assumes the bench chooses which pads the board pulls low.
`timescale 1ns/100ps
`default_nettype none
module gam_board
  import gam_pkg::*;
(
  // Device side
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOe,
  // Board pull-down requests
  input wire logic [PIN_COUNT-1:0] drvLow,
  // Resolved level
  output logic [PIN_COUNT-1:0] pad
);
  // Expanders signal by pulling low and float high when idle
  assign pad = (pinOe & pinOut) | (~pinOe & ~drvLow);
endmodule
`default_nettype wire

// *** verification/gam_pin_mux_tb.sv ***
// Bench for the pin mux, driven through its register bus.
// Assumes the board model resolves every pad for the pad inputs.
`timescale 1ns/100ps
`default_nettype none
module gam_pin_mux_tb
  import gam_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, irqOut;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] pinOut, pinOe, pad, drvLow = 16'h0000;
  int fail_count = 0, compares = 0, cycles = 0;
  int pinOf [8] = '{8, 0, 9, 1, 10, 11, 12, 7};
  always #12.5 clk = ~clk;
  gam_pin_mux #(.PINS(PIN_COUNT)) uut (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pinIn(pad),
    .pinOut(pinOut), .pinOe(pinOe), .irqOut(irqOut));
  gam_board brd (.pinOut(pinOut), .pinOe(pinOe), .drvLow(drvLow), .pad(pad));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Both write channels offered at once, each dropped when taken
  // bready and rready stay high once raised, so calls can follow back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    sys_rst <= 1'b0;
    cyc(1);
    rdr(OFF_FUNC_SEL);
    chk("fsel reset", rd, 32'h00000000);
    chk("fsel resp", rsp, RESP_OKAY);
    chk("oe reset", pinOe, 16'h0000);
    rdr(8'h40);
    chk("unmapped resp", rsp, RESP_SLVERR);
    chk("unmapped data", rd, 32'h00000000);
    wr(8'h40, 32'h0000FFFF);
    chk("unmapped wr resp", rsp, RESP_SLVERR);
    $display("test bus responses done");
    wr(OFF_DIR, 32'h0000FFFF);
    chk("dir resp", rsp, RESP_OKAY);
    wr(OFF_OUT_DATA, 32'h0000A5A5);
    cyc(1);
    chk("gpio oe", pinOe, 16'hFFFF);
    chk("gpio pad", pad, 16'hA5A5);
    $display("test gpio output done");
    // Every alternate output in turn; pads 13..15 keep their data
    wr(OFF_FUNC_SEL, 32'h0000FFFF);
    for (int k = 0; k < 8; k++) begin
      wr(OFF_ALT_CTRL, 32'h1 << k);
      cyc(1);
      chk("alt oe", pinOe, 16'hFF83);
      chk("alt pad", pad, 16'hBFFF & ~(16'h1 << pinOf[k]));
    end
    $display("test alternate outputs done");
    wr(OFF_IRQ_MASK, 32'h0000003C);
    wr(OFF_IRQ_EN, 32'h0000407C);
    for (int i = 0; i < 4; i++) begin
      drvLow <= 16'h0004 << i;
      cyc(6);
      rdr(OFF_EXP_STAT);
      chk("exp stat", rd, 32'h1 << i);
      chk("irq raised", irqOut, 1'b1);
      drvLow <= 16'h0000;
      wr(OFF_IRQ_STAT, 32'h4 << i);
      cyc(6);
      chk("irq cleared", irqOut, 1'b0);
    end
    drvLow <= 16'h0040;
    cyc(6);
    rdr(OFF_IRQ_STAT);
    chk("reserved alt", rd, 32'h00000000);
    $display("test expander inputs done");
    // Pad 14 as plain input despite its select bit; masked at first
    wr(OFF_DIR, 32'h00000000);
    cyc(6);
    wr(OFF_IRQ_STAT, 32'h0000FFFF);
    drvLow <= 16'h4040;
    cyc(6);
    rdr(OFF_PIN_IN);
    chk("pin in", rd & 32'hE000, 32'hA000);
    rdr(OFF_IRQ_STAT);
    chk("gpio event", rd, 32'h00004000);
    chk("irq masked", irqOut, 1'b0);
    wr(OFF_IRQ_MASK, 32'h00004000);
    cyc(3);
    chk("irq unmasked", irqOut, 1'b1);
    $display("test gpio input done");
    test_done();
  end
endmodule
`default_nettype wire
